// *** pkg/nvseq_params.svh ***
`ifndef NVSEQ_PARAMS_SVH
`define NVSEQ_PARAMS_SVH
`define NVSEQ_REG_CTRL      8'ha1
`define NVSEQ_REG_WSEL      8'ha2
`define NVSEQ_REG_WVAL      8'ha3
`define NVSEQ_REG_ENABLE    8'hc4
`define NVSEQ_CORNER_BASE   8'h20
`define NVSEQ_SHADOW_BASE   8'h40
`define NVSEQ_SHADOW_END    8'h60
`define NVSEQ_NV_WORDS      8'h40
`define NVSEQ_EN_VALUE      24'h000001
`define NVSEQ_CTL_PULSE     0
`define NVSEQ_CTL_WIPE      1
`define NVSEQ_CTL_WRITE     2
`define NVSEQ_CTL_READSEL   3
`define NVSEQ_CTL_MSB       3
`define NVSEQ_WSEL_MSB      5
`define NVSEQ_DATA_MSB      17
`define NVSEQ_SHADOW_MSB    4
`define NVSEQ_PULSE_MS      15
`define NVSEQ_CLK_KHZ       100000
`define NVSEQ_PULSE_CYC     (`NVSEQ_PULSE_MS * `NVSEQ_CLK_KHZ)
`endif

// *** pkg/nvseq_pkg.sv ***
package nvseq_pkg;
	typedef enum logic [1:0] {
		NVSEQ_IDLE  = 2'b00,
		NVSEQ_WIPE  = 2'b01,
		NVSEQ_WRITE = 2'b10
	} nvseq_mode_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [23:0] wdata;
	} nvseq_req_t;

	typedef struct packed {
		logic        rvalid;
		logic [23:0] rdata;
	} nvseq_rsp_t;
endpackage : nvseq_pkg

// *** hdl/nvseq_core.sv ***
// What this block does
// [RULE1] Sixty-four words of 24 bits
// [RULE2] Upper six check bits, lower 18 data
// [RULE3] Host enables access writing one to 196
// [RULE4] Host writes zero to leave access
// [RULE5] Erase four writes, program three writes
// [RULE6] Read at word address returns word
// [RULE7] Host programs singly, erases before writing
// [RULE8] Change takes about 30 plus 15 ms
// [RULE9] Pulse bit starts pulse, self-clears by 15 ms
// [RULE10] Erase sets bit one with pulse
// [RULE11] Program sets bit two with pulse
// [RULE12] Read-select bit not needed for reads
// [RULE13] Host writes zero to unused upper bits
// [RULE14] Address bits 5:0 pick target word
// [RULE15] Data-in bits 17:0 hold new data
// [RULE16] Erase: address, zero, 3, wait, 3, wait
// [RULE17] Write: address, data, 5, wait 15 ms
// [RULE18] Words 32-63 hold curve corner points
// [RULE19] Words below 32 shadowed at plus 64
// [RULE20] Pulses ignored unless enabled; poll pulse bit
// [RULE21] Both or neither select bits: no-op
`include "nvseq_params.svh"
module nvseq_core
	import nvseq_pkg::*;
#(
	parameter int PULSE_CYC = `NVSEQ_PULSE_CYC
) (
	input  wire logic       clk,      // 100 MHz
	input  wire logic       reset_n,  // Sync, active low
	input  wire nvseq_req_t req,      // Register access from serial front end
	output nvseq_rsp_t      rsp,      // Read answer, one cycle later
	output logic            busy      // High-voltage pulse in progress
);
	// Pulse counter is 24 bits; a longer pulse cannot be timed
	if (PULSE_CYC < 1 || PULSE_CYC > 24'hffffff) begin : g_pulse_range
		$error("PULSE_CYC out of range");
	end

	typedef struct packed {
		logic [3:0]  ctrl;
		logic [5:0]  wsel;
		logic [17:0] wval;
		logic        enable;
		nvseq_mode_t mode;
		logic [23:0] cnt;
		logic [31:0][17:0] shadow;
		nvseq_rsp_t  rsp;
	} nvseq_state_t;

	nvseq_state_t st_r;
	nvseq_state_t st_nxt;

	// Nonvolatile array kept outside the struct: too large to pack
	logic [23:0] nv_mem [0:63];
	logic        nv_we;
	logic [5:0]  nv_waddr;
	logic [23:0] nv_wdata;

	////////////////////////////////////////////////////////////////////////
	// Check bits: position code over slots 3..23, data skips powers of two,
	// plus overall parity so a double error is never miscorrected
	function automatic logic [5:0] nvseq_ecc(input logic [17:0] d);
		logic [5:0] c;
		logic [4:0] pos;
		int         k;
		c   = 6'h00;
		pos = 5'h00;
		k   = 0;
		for (int p = 3; p < 24; p++) begin
			if ((p & (p - 1)) != 0) begin
				pos = p[4:0];
				for (int b = 0; b < 5; b++) begin
					if (pos[b]) begin
						c[b] = c[b] ^ d[k];
					end
				end
				k++;
			end
		end
		// Overall parity spans data and the five position bits
		c[5] = ^{d, c[4:0]};
		return c;
	endfunction : nvseq_ecc

	// Single error: syndrome names the flipped slot, overall parity odd.
	// Double error: parity even, data passed on uncorrected
	function automatic logic [17:0] nvseq_fix(input logic [23:0] w);
		logic [5:0]  c;
		logic [5:0]  s;
		logic [17:0] d;
		logic [4:0]  pos;
		int          k;
		d   = w[17:0];
		c   = nvseq_ecc(d);
		s   = {^w, c[4:0] ^ w[22:18]};
		pos = 5'h00;
		k   = 0;
		for (int p = 3; p < 24; p++) begin
			if ((p & (p - 1)) != 0) begin
				pos = p[4:0];
				if (s[5] && s[4:0] == pos) begin
					d[k] = ~d[k];
				end
				k++;
			end
		end
		return d;
	endfunction : nvseq_fix

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt   = st_r;
		nv_we    = 1'b0;
		nv_waddr = st_r.wsel;
		nv_wdata = 24'h000000;
		st_nxt.rsp.rvalid = 1'b0;
		st_nxt.rsp.rdata  = 24'h000000;

		// [RULE8] one pulse per phase
		// [RULE9] pulse timing, self-clear
		if (st_r.mode != NVSEQ_IDLE) begin
			if (st_r.cnt == 24'h000001) begin
				st_nxt.mode = NVSEQ_IDLE;
				st_nxt.ctrl[`NVSEQ_CTL_PULSE] = 1'b0;
				nv_we = 1'b1;
				// [RULE2] check bits generated here
				if (st_r.mode == NVSEQ_WIPE) begin
					nv_wdata = 24'h000000;
				end else begin
					nv_wdata = {nvseq_ecc(st_r.wval), st_r.wval};
				end
			end
			st_nxt.cnt = st_r.cnt - 24'h000001;
		end

		if (req.wr) begin
			unique case (req.addr)
				`NVSEQ_REG_ENABLE: begin
					// Exact value only, so a stray write cannot arm pulses
					// [RULE3] access enable
					st_nxt.enable = (req.wdata == `NVSEQ_EN_VALUE);
				end
				`NVSEQ_REG_WSEL: begin
					// [RULE14] target word
					if (st_r.mode == NVSEQ_IDLE) st_nxt.wsel = req.wdata[`NVSEQ_WSEL_MSB:0];
				end
				`NVSEQ_REG_WVAL: begin
					// [RULE15] new data
					if (st_r.mode == NVSEQ_IDLE) st_nxt.wval = req.wdata[`NVSEQ_DATA_MSB:0];
				end
				`NVSEQ_REG_CTRL: begin
					if (st_r.mode == NVSEQ_IDLE) begin
						// [RULE12] read-select just stored
						st_nxt.ctrl = req.wdata[`NVSEQ_CTL_MSB:0];
						st_nxt.ctrl[`NVSEQ_CTL_PULSE] = 1'b0;
						// [RULE20] gated by enable
						if (req.wdata[`NVSEQ_CTL_PULSE] && st_r.enable) begin
							// [RULE21] ambiguous select is no-op
							if (req.wdata[`NVSEQ_CTL_WIPE] && !req.wdata[`NVSEQ_CTL_WRITE]) begin
								// [RULE10] erase start
								st_nxt.mode = NVSEQ_WIPE;
								st_nxt.ctrl[`NVSEQ_CTL_PULSE] = 1'b1;
								st_nxt.cnt  = PULSE_CYC[23:0];
							end else if (req.wdata[`NVSEQ_CTL_WRITE] && !req.wdata[`NVSEQ_CTL_WIPE]) begin
								// [RULE11] write start
								st_nxt.mode = NVSEQ_WRITE;
								st_nxt.ctrl[`NVSEQ_CTL_PULSE] = 1'b1;
								st_nxt.cnt  = PULSE_CYC[23:0];
							end
						end
					end
				end
				default: begin
					// [RULE19] shadow copies writable
					if (req.addr >= `NVSEQ_SHADOW_BASE && req.addr < `NVSEQ_SHADOW_END)
						st_nxt.shadow[req.addr[`NVSEQ_SHADOW_MSB:0]] = req.wdata[`NVSEQ_DATA_MSB:0];
				end
			endcase
		end

		if (req.rd) begin
			st_nxt.rsp.rvalid = 1'b1;
			// [RULE6] direct word read
			if (req.addr < `NVSEQ_NV_WORDS) begin
				// [RULE18] corner words read the same way
				st_nxt.rsp.rdata = {6'h00, nvseq_fix(nv_mem[req.addr[`NVSEQ_WSEL_MSB:0]])};
			end else if (req.addr < `NVSEQ_SHADOW_END) begin
				st_nxt.rsp.rdata = {6'h00, st_r.shadow[req.addr[`NVSEQ_SHADOW_MSB:0]]};
			end else if (req.addr == `NVSEQ_REG_CTRL) begin
				// [RULE20] pulse bit pollable
				st_nxt.rsp.rdata = {20'h00000, st_r.ctrl};
			end else if (req.addr == `NVSEQ_REG_WSEL) begin
				st_nxt.rsp.rdata = {18'h00000, st_r.wsel};
			end else if (req.addr == `NVSEQ_REG_WVAL) begin
				st_nxt.rsp.rdata = {6'h00, st_r.wval};
			end else if (req.addr == `NVSEQ_REG_ENABLE) begin
				st_nxt.rsp.rdata = {23'h000000, st_r.enable};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// [RULE1] 64 x 24 array
	always_ff @(posedge clk) begin
		if (nv_we) begin
			nv_mem[nv_waddr] <= nv_wdata;
		end
	end

	// Busy mirrors pulse bit; registered via state
	assign rsp  = st_r.rsp;
	assign busy = st_r.ctrl[`NVSEQ_CTL_PULSE];
endmodule : nvseq_core

// *** bench/nvseq_chk_sva.sv ***
module nvseq_chk
	import nvseq_pkg::*;
#(
	parameter int PULSE_CYC = 20
) (
	input wire logic       clk,      // Clock
	input wire logic       reset_n,  // Reset
	input wire nvseq_req_t req,      // Request
	input wire nvseq_rsp_t rsp,      // Answer
	input wire logic       busy      // Pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIM = PULSE_CYC + 2;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_noop;
		req.wr && !busy && req.addr == 8'ha1 && req.wdata[0] && req.wdata[2:1] inside {2'b00, 2'b11};
	endsequence
	AST_RD: assert property (req.rd |=> rsp.rvalid) else $error("no read answer");
	AST_NORD: assert property (!req.rd |=> !rsp.rvalid) else $error("stray rvalid");
	AST_ZERO: assert property (!rsp.rvalid |-> rsp.rdata == 24'h000000) else $error("rdata not zero");
	AST_ECC: assert property (rsp.rvalid |-> rsp.rdata[23:18] == 6'h00) else $error("check bits shown");
	AST_END: assert property ($rose(busy) |-> ##[1:LIM] !busy) else $error("pulse too long");
	AST_HOLD: assert property ($rose(busy) |-> busy [*8]) else $error("pulse too short");
	AST_GO: assert property ($rose(busy) |-> $past(req.wr) && $past(req.addr) == 8'ha1) else $error("bad start");
	AST_NOP: assert property (s_noop |=> !busy) else $error("no-op pulsed");
endmodule : nvseq_chk
bind nvseq_core nvseq_chk #(.PULSE_CYC(PULSE_CYC)) chk_u (.clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp), .busy(busy));

// *** bench/nvseq_host.sv ***
module nvseq_host
	import nvseq_pkg::*;
(
	input  wire logic       clk,   // Clock
	input  wire logic       busy,  // Pulse running
	input  wire nvseq_rsp_t rsp,   // Read answer
	output nvseq_req_t      req    // Request
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	// Idle lines show inverse so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk) #1 req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) #1 req <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [23:0] q);
		@(posedge clk) #1 req <= '{1'b0, 1'b1, a, 24'h000000};
		@(posedge clk) #1 req <= '{1'b0, 1'b0, ~a, 24'hffffff};
		q = rsp.rdata;
	endtask : rd
	task automatic idle();
		for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
	endtask : idle
	task automatic erase(input logic [7:0] a);
		wr(8'ha2, {18'h0, a[5:0]});
		wr(8'ha3, 24'h000000);
		wr(8'ha1, 24'h000003);
		idle();
		wr(8'ha1, 24'h000003);
		idle();
	endtask : erase
	task automatic prog(input logic [7:0] a, input logic [17:0] d);
		wr(8'ha2, {18'h0, a[5:0]});
		wr(8'ha3, {6'h00, d});
		wr(8'ha1, 24'h000005);
		idle();
	endtask : prog
endmodule : nvseq_host

// *** bench/tb_eeprom_program_sequencer.sv ***
module tb_eeprom_program_sequencer
	import nvseq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	nvseq_req_t  req;
	nvseq_rsp_t  rsp;
	logic        busy;
	logic [23:0] q;
	int          fail_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	always #5 clk = ~clk;
	nvseq_core #(.PULSE_CYC(20)) dut_u (.clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp), .busy(busy));
	nvseq_host h (.clk(clk), .busy(busy), .rsp(rsp), .req(req));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// Run is bounded at 5000 cycles; idle gives up after 100, so a stuck busy shows in the busy checks
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic t_prog();
		h.wr(8'hc4, 24'h000001);
		h.erase(8'h07);
		h.rd(8'h07, q);
		chk(q, 24'h000000);
		chk({23'h0, rsp.rvalid}, 24'h000001);
		h.wr(8'ha2, 24'h000007);
		h.wr(8'ha3, 24'h000105);
		h.wr(8'ha1, 24'h000005);
		chk({23'h0, busy}, 24'h000001);
		h.rd(8'ha1, q);
		chk(q, 24'h000005);
		h.idle();
		chk({23'h0, busy}, 24'h000000);
		h.rd(8'ha1, q);
		chk(q, 24'h000004);
		h.rd(8'h07, q);
		chk(q, 24'h000105);
		h.erase(8'h28);
		h.prog(8'h28, 18'h3fe01);
		h.rd(8'h28, q);
		chk(q, 24'h03fe01);
		$display("test prog done");
	endtask : t_prog
	task automatic t_refuse();
		h.wr(8'ha1, 24'h000007);
		chk({23'h0, busy}, 24'h000000);
		h.wr(8'ha1, 24'h000001);
		chk({23'h0, busy}, 24'h000000);
		h.wr(8'ha1, 24'h000008);
		h.rd(8'ha1, q);
		chk(q, 24'h000008);
		h.wr(8'hc4, 24'h000000);
		h.wr(8'ha1, 24'h000003);
		chk({23'h0, busy}, 24'h000000);
		h.idle();
		h.rd(8'h28, q);
		chk(q, 24'h03fe01);
		h.rd(8'hff, q);
		chk(q, 24'h000000);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_shadow();
		h.wr(8'h4e, 24'h000abc);
		h.rd(8'h4e, q);
		chk(q, 24'h000abc);
		$display("test shadow done");
	endtask : t_shadow
	initial begin
		repeat (5) @(posedge clk);
		#1 reset_n = 1'b1;
		t_prog();
		t_refuse();
		t_shadow();
		tally_and_finish();
	end
endmodule : tb_eeprom_program_sequencer
